// ### include/xbar_pkg.sv
// Constants and carrier types for the port crossbar and match block
package xbar_pkg;
   // Register addresses on the special function register port
   localparam logic [7:0] ADDR_ROUTE_A = 8'he1;
   localparam logic [7:0] ADDR_ROUTE_B = 8'he2;
   localparam logic [7:0] ADDR_P0_MATCH = 8'hfd;
   localparam logic [7:0] ADDR_P0_MASK = 8'hfe;
   localparam logic [7:0] ADDR_P1_MATCH = 8'hed;
   localparam logic [7:0] ADDR_P1_MASK = 8'hee;
   // Values after reset
   localparam logic [7:0] RST_ROUTE_A = 8'h00;
   localparam logic [7:0] RST_ROUTE_B = 8'h00;
   localparam logic [7:0] RST_MATCH = 8'hff;
   localparam logic [7:0] RST_MASK = 8'h00;
   // Writable bits; the rest read as zero
   localparam logic [7:0] WMASK_ROUTE_A = 8'h3f;
   localparam logic [7:0] WMASK_ROUTE_B = 8'hfb;
   // Field positions, first routing register
   localparam int BIT_ASYNC_CMP = 5;
   localparam int BIT_CMP = 4;
   localparam int BIT_SYSCLK = 3;
   localparam int BIT_TWO_WIRE = 2;
   localparam int BIT_SPI = 1;
   localparam int BIT_UART = 0;
   // Field positions, second routing register
   localparam int BIT_PULLUP_DIS = 7;
   localparam int BIT_XBAR = 6;
   localparam int BIT_TIMER1 = 5;
   localparam int BIT_TIMER0 = 4;
   localparam int BIT_CNT_CLK = 3;
   localparam int CC_SEL_LSB = 0;
   // Fixed UART pins on port 0
   localparam int UART_TX_PIN = 4;
   localparam int UART_RX_PIN = 5;
   // Pins per port and pins compared across both ports
   localparam int PORT_W = 8;
   localparam int PIN_W = 16;
   // Pin level to mismatch output latency in clock cycles
   localparam int MATCH_LATENCY = 3;

   // Which peripheral functions currently reach the pins
   typedef struct packed {
      logic async_cmp;
      logic cmp;
      logic sysclk;
      logic two_wire;
      logic spi_core;
      logic spi_nss;
      logic uart;
      logic timer1;
      logic timer0;
      logic cnt_clk;
      logic [2:0] cc;
   } route_s;

   // Pin-side inputs that feed peripherals
   typedef struct packed {
      logic timer1;
      logic timer0;
      logic cnt_clk;
      logic [2:0] cc;
   } fn_in_s;

   // Peripheral outputs headed for pins
   typedef struct packed {
      logic async_cmp;
      logic cmp;
      logic [2:0] cc;
   } fn_out_s;
endpackage

// ### verification/pin_side_model.sv
// Pin pads and outside drivers seen across the crossbar
`timescale 1ns/10ps
module pin_side_model
   import xbar_pkg::*;
(
   // Design pin side
   input wire logic [PIN_W-1:0] pin_out,
   input wire logic [PIN_W-1:0] pin_oe,
   input wire logic [PIN_W-1:0] pullup_en,
   // Outside drivers from the bench
   input wire logic [PIN_W-1:0] ext_en,
   input wire logic [PIN_W-1:0] ext_level,
   // Resolved pad levels
   output logic [PIN_W-1:0] pin_in
);
   // Design drive wins, then an enabled outside driver; an undriven pad goes to its pullup or else shows the
   // inverse of the outside level, so a stale value never passes for a match
   always_comb begin
      for (int i = 0; i < PIN_W; i++) begin
         if (pin_oe[i]) begin
            pin_in[i] = pin_out[i];
         end else if (ext_en[i]) begin
            pin_in[i] = ext_level[i];
         end else begin
            pin_in[i] = pullup_en[i] | ~ext_level[i];
         end
      end
   end
endmodule // pin_side_model

// ### verification/testbench.sv
// Self-checking bench for the port crossbar and match block
`timescale 1ns/10ps
module testbench;
   import xbar_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic [PIN_W-1:0] pin_in, pin_out, pin_oe, pullup_en;
   logic [PIN_W-1:0] pin_digital = 16'hf0f0;
   logic [PIN_W-1:0] gpio_out = 16'ha5a5;
   logic [PIN_W-1:0] gpio_oe_req = 16'hffff;
   logic [PIN_W-1:0] ext_level = 16'hff00;
   fn_out_s fn_out = 5'h1f;
   fn_in_s fn_pin = 6'h3f;
   logic uart_transmit = 1'b1;
   logic spi_four_wire = 1'b1;
   fn_out_s fn_pin_out;
   fn_in_s fn_in;
   route_s route;
   logic uart_receive, sysclk_pin_out, port_mismatch, mismatch_irq_src, mismatch_wake;
   logic [2:0] exp_cc;
   logic s0;
   int mismatches = 0;
   int num_checks = 0;

   always #2 clk = ~clk;

   port_crossbar_and_match port_crossbar_and_match_inst (
      .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .pin_in(pin_in),
      .pin_digital(pin_digital), .gpio_out(gpio_out), .gpio_oe_req(gpio_oe_req),
      .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .fn_out(fn_out),
      .fn_pin(fn_pin), .uart_transmit(uart_transmit), .spi_four_wire(spi_four_wire),
      .fn_pin_out(fn_pin_out), .fn_in(fn_in), .uart_receive(uart_receive),
      .sysclk_pin_out(sysclk_pin_out), .route(route), .port_mismatch(port_mismatch),
      .mismatch_irq_src(mismatch_irq_src), .mismatch_wake(mismatch_wake));

   // Pin 4 left to the design, since it carries the transmit line
   pin_side_model pin_side_model_inst (
      .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
      .ext_en(16'hffef), .ext_level(ext_level), .pin_in(pin_in));

   // Value comparison and report
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Register port cycles, inputs moved on the falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      cmp(16'(sfr_rdata), 16'(exp));
   endtask

   // Lets the register update and the registered outputs land
   task automatic settle;
      repeat (2) @(negedge clk);
   endtask

   task automatic end_sim;
      if (mismatches == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      end_sim;
   end

   // Main sequence
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      rd(ADDR_ROUTE_A, 8'h00);
      rd(ADDR_ROUTE_B, 8'h00);
      rd(ADDR_P0_MATCH, 8'hff);
      rd(ADDR_P0_MASK, 8'h00);
      rd(ADDR_P1_MATCH, 8'hff);
      rd(ADDR_P1_MASK, 8'h00);
      rd(8'h55, 8'h00);
      // Every routing bit set but the crossbar off; drive requests all high
      wr(ADDR_ROUTE_A, 8'hff);
      wr(ADDR_ROUTE_B, 8'hbf);
      rd(ADDR_ROUTE_A, 8'h3f);
      rd(ADDR_ROUTE_B, 8'hbb);
      settle;
      cmp(16'(route), 16'h0000);
      cmp(pin_oe, 16'h0000);
      cmp(pullup_en, 16'h0000);
      cmp(16'(fn_in), 16'h0000);
      cmp(16'(fn_pin_out), 16'h0000);
      cmp(16'(uart_receive), 16'h0001);
      cmp(16'(sysclk_pin_out), 16'h0000);
      // Crossbar on with everything routed
      gpio_oe_req = 16'h0000;
      wr(ADDR_ROUTE_B, 8'hff);
      rd(ADDR_ROUTE_B, 8'hfb);
      settle;
      cmp(16'(route), 16'h1fff);
      cmp(16'(fn_in), 16'h003f);
      cmp(16'(fn_pin_out), 16'h001f);
      cmp(16'(pin_oe[5:4]), 16'h0001);
      cmp(16'(pin_out[4]), 16'h0001);
      cmp(16'(uart_receive), 16'h0000);
      uart_transmit = 1'b0;
      settle;
      cmp(16'(pin_out[4]), 16'h0000);
      s0 = sysclk_pin_out;
      @(negedge clk);
      cmp(16'(sysclk_pin_out), {15'h0000, ~s0});
      // One route enable at a time, three-wire SPI
      spi_four_wire = 1'b0;
      wr(ADDR_ROUTE_B, 8'h40);
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_ROUTE_A, 8'(1 << i));
         settle;
         cmp(16'(route), 16'h0001 << ((i == 0) ? 6 : i + 7));
         cmp(16'(fn_pin_out), (i == 5) ? 16'h10 : (i == 4) ? 16'h08 : 16'h0);
      end
      spi_four_wire = 1'b1;
      wr(ADDR_ROUTE_A, 8'h02);
      settle;
      cmp(16'(route), 16'h0180);
      // Every capture/compare code with input enables set from the code bits and pullups on
      wr(ADDR_ROUTE_A, 8'h00);
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_ROUTE_B, {2'b01, k[0], k[1], k[0], 1'b0, k[1:0]});
         settle;
         exp_cc = {k == 3, k > 1, k > 0};
         cmp(16'(route), {10'h0, k[0], k[1], k[0], exp_cc});
         cmp(16'(fn_in), {10'h0, k[0], k[1], k[0], exp_cc});
         cmp(16'(fn_pin_out), {13'h0, exp_cc});
         cmp(pullup_en, pin_digital);
      end
      // Port 0 match with the crossbar off
      wr(ADDR_ROUTE_B, 8'h00);
      ext_level = 16'h0001;
      repeat (4) @(negedge clk);
      cmp(16'(port_mismatch), 16'h0000);
      wr(ADDR_P0_MASK, 8'h01);
      wr(ADDR_P0_MATCH, 8'h00);
      settle;
      cmp(16'({port_mismatch, mismatch_irq_src, mismatch_wake}), 16'h0007);
      repeat (6) @(negedge clk);
      cmp(16'(port_mismatch), 16'h0001);
      ext_level[0] = 1'b0;
      @(negedge clk);
      cmp(16'(port_mismatch), 16'h0001);
      repeat (2) @(negedge clk);
      cmp(16'(port_mismatch), 16'h0000);
      // Port 1 match while the UART is routed
      wr(ADDR_ROUTE_A, 8'h01);
      wr(ADDR_ROUTE_B, 8'h40);
      wr(ADDR_P1_MASK, 8'h80);
      wr(ADDR_P1_MATCH, 8'h80);
      settle;
      cmp(16'(port_mismatch), 16'h0001);
      ext_level[15] = 1'b1;
      repeat (3) @(negedge clk);
      cmp(16'(port_mismatch), 16'h0000);
      // Latch data and drive requests pass with the crossbar on; UART keeps P0.4, frees P0.5
      gpio_oe_req = 16'h0f2f;
      uart_transmit = 1'b1;
      settle;
      cmp(pin_oe, 16'h0f1f);
      cmp(pin_out, 16'ha5b5);
      end_sim;
   end
endmodule // testbench

// ### verilog/port_crossbar_and_match.sv
// Port crossbar routing enables, pullup control and port match detector
`timescale 1ns/10ps
module port_crossbar_and_match (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Special function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Pins: port 1 in the upper byte, port 0 in the lower
   input wire logic [xbar_pkg::PIN_W-1:0] pin_in,
   input wire logic [xbar_pkg::PIN_W-1:0] pin_digital,
   input wire logic [xbar_pkg::PIN_W-1:0] gpio_out,
   input wire logic [xbar_pkg::PIN_W-1:0] gpio_oe_req,
   output logic [xbar_pkg::PIN_W-1:0] pin_out,
   output logic [xbar_pkg::PIN_W-1:0] pin_oe,
   output logic [xbar_pkg::PIN_W-1:0] pullup_en,
   // Peripheral side
   input wire xbar_pkg::fn_out_s fn_out,
   input wire xbar_pkg::fn_in_s fn_pin,
   input wire logic uart_transmit,
   input wire logic spi_four_wire,
   output xbar_pkg::fn_out_s fn_pin_out,
   output xbar_pkg::fn_in_s fn_in,
   output logic uart_receive,
   output logic sysclk_pin_out,
   output xbar_pkg::route_s route,
   // Port match event
   output logic port_mismatch,
   output logic mismatch_irq_src,
   output logic mismatch_wake
);
   import xbar_pkg::*;

   logic [7:0] route_a;
   logic [7:0] route_b;
   logic [7:0] p0_match;
   logic [7:0] p0_mask;
   logic [7:0] p1_match;
   logic [7:0] p1_mask;
   logic sysclk_div;
   logic mismatch_level;

   // Address decode
   wire sel_a = sfr_addr == ADDR_ROUTE_A;
   wire sel_b = sfr_addr == ADDR_ROUTE_B;
   wire sel_p0_match = sfr_addr == ADDR_P0_MATCH;
   wire sel_p0_mask = sfr_addr == ADDR_P0_MASK;
   wire sel_p1_match = sfr_addr == ADDR_P1_MATCH;
   wire sel_p1_mask = sfr_addr == ADDR_P1_MASK;

   // Read mux; unmapped addresses return zero
   wire [7:0] rd_mux = sel_a ? route_a :
                       sel_b ? route_b :
                       sel_p0_match ? p0_match :
                       sel_p0_mask ? p0_mask :
                       sel_p1_match ? p1_match :
                       sel_p1_mask ? p1_mask : 8'h00;

   // Register writes; read-only bits are masked off at the write
   always_ff @(posedge clk) begin
      if (rst) begin
         route_a <= RST_ROUTE_A;
         route_b <= RST_ROUTE_B;
         p0_match <= RST_MATCH;
         p0_mask <= RST_MASK;
         p1_match <= RST_MATCH;
         p1_mask <= RST_MASK;
      end else if (sfr_wr) begin
         if (sel_a) route_a <= sfr_wdata & WMASK_ROUTE_A;
         if (sel_b) route_b <= sfr_wdata & WMASK_ROUTE_B;
         if (sel_p0_match) p0_match <= sfr_wdata;
         if (sel_p0_mask) p0_mask <= sfr_wdata;
         if (sel_p1_match) p1_match <= sfr_wdata;
         if (sel_p1_mask) p1_mask <= sfr_wdata;
      end
   end

   // Read data registered, valid the cycle after the read strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         sfr_rdata <= rd_mux;
      end
   end

   // Crossbar gate: nothing is routed until the crossbar is enabled
   wire xbar_en = route_b[BIT_XBAR];
   wire pullup_off = route_b[BIT_PULLUP_DIS];
   wire [1:0] cc_sel = route_b[CC_SEL_LSB +: 2];
   wire [2:0] cc_dec = (cc_sel == 2'b11) ? 3'b111 :
                       (cc_sel == 2'b10) ? 3'b011 :
                       (cc_sel == 2'b01) ? 3'b001 : 3'b000;

   route_s next_route;
   always_comb begin
      next_route.async_cmp = xbar_en & route_a[BIT_ASYNC_CMP];
      next_route.cmp = xbar_en & route_a[BIT_CMP];
      next_route.sysclk = xbar_en & route_a[BIT_SYSCLK];
      next_route.two_wire = xbar_en & route_a[BIT_TWO_WIRE];
      next_route.spi_core = xbar_en & route_a[BIT_SPI];
      next_route.spi_nss = xbar_en & route_a[BIT_SPI] & spi_four_wire;
      next_route.uart = xbar_en & route_a[BIT_UART];
      next_route.timer1 = xbar_en & route_b[BIT_TIMER1];
      next_route.timer0 = xbar_en & route_b[BIT_TIMER0];
      next_route.cnt_clk = xbar_en & route_b[BIT_CNT_CLK];
      next_route.cc = xbar_en ? cc_dec : 3'b000;
   end

   // Gated peripheral signals in both directions
   fn_out_s next_fn_pin_out;
   fn_in_s next_fn_in;
   always_comb begin
      next_fn_pin_out.async_cmp = next_route.async_cmp & fn_out.async_cmp;
      next_fn_pin_out.cmp = next_route.cmp & fn_out.cmp;
      next_fn_pin_out.cc = next_route.cc & fn_out.cc;
      next_fn_in.timer1 = next_route.timer1 & fn_pin.timer1;
      next_fn_in.timer0 = next_route.timer0 & fn_pin.timer0;
      next_fn_in.cnt_clk = next_route.cnt_clk & fn_pin.cnt_clk;
      next_fn_in.cc = next_route.cc & fn_pin.cc;
   end

   // Pin drivers: all off with the crossbar disabled; UART owns P0.4
   logic [PIN_W-1:0] next_pin_oe;
   logic [PIN_W-1:0] next_pin_out;
   always_comb begin
      next_pin_oe = xbar_en ? gpio_oe_req : '0;
      next_pin_out = gpio_out;
      if (next_route.uart) begin
         next_pin_oe[UART_TX_PIN] = 1'b1;
         next_pin_out[UART_TX_PIN] = uart_transmit;
         next_pin_oe[UART_RX_PIN] = 1'b0;
      end
   end

   // Receive idles high when not routed, as an idle UART line would
   wire next_uart_rx = next_route.uart ? pin_in[UART_RX_PIN] : 1'b1;

   // Analog pins never get a pullup, whatever the disable bit says
   wire [PIN_W-1:0] next_pullup = pullup_off ? '0 : pin_digital;

   // Divide-by-two system clock; kept running so enabling it is glitch free
   always_ff @(posedge clk) begin
      if (rst) begin
         sysclk_div <= 1'b0;
      end else begin
         sysclk_div <= ~sysclk_div;
      end
   end

   // All pin and peripheral outputs leave from flops; one cycle of lag
   // on the comparator paths is the price of a clean output timing
   always_ff @(posedge clk) begin
      if (rst) begin
         route <= '0;
         fn_pin_out <= '0;
         fn_in <= '0;
         pin_oe <= '0;
         pin_out <= '0;
         pullup_en <= '0;
         uart_receive <= 1'b1;
         sysclk_pin_out <= 1'b0;
      end else begin
         route <= next_route;
         fn_pin_out <= next_fn_pin_out;
         fn_in <= next_fn_in;
         pin_oe <= next_pin_oe;
         pin_out <= next_pin_out;
         pullup_en <= next_pullup;
         uart_receive <= next_uart_rx;
         sysclk_pin_out <= next_route.sysclk & sysclk_div;
      end
   end

   // Match detector sees raw pins, not crossbar-gated ones
   port_match_cmp #(
      .W(PIN_W)
   ) u_match (
      .clk(clk),
      .rst(rst),
      .pins(pin_in),
      .mask({p1_mask, p0_mask}),
      .match({p1_match, p0_match}),
      .mismatch(mismatch_level)
   );

   // One level fans out to the interrupt and wakeup controllers
   assign port_mismatch = mismatch_level;
   assign mismatch_irq_src = mismatch_level;
   assign mismatch_wake = mismatch_level;

   // Checks
   ro_route_a_a: assert property (@(posedge clk) disable iff (rst)
      sfr_rd && sel_a |=> sfr_rdata[7:6] == 2'b00)
      else $error("route A top bits not zero");

   ro_route_b_a: assert property (@(posedge clk) disable iff (rst)
      sfr_rd && sel_b |=> sfr_rdata[2] == 1'b0)
      else $error("route B bit 2 not zero");

   oe_off_a: assert property (@(posedge clk) disable iff (rst)
      !xbar_en |=> pin_oe == '0)
      else $error("driver on while crossbar off");

   no_route_a: assert property (@(posedge clk) disable iff (rst)
      !xbar_en |=> route == '0 && fn_in == '0 && uart_receive)
      else $error("function routed while crossbar off");

   uart_pin_a: assert property (@(posedge clk) disable iff (rst)
      xbar_en && route_a[BIT_UART] |=>
      pin_oe[UART_TX_PIN] && pin_out[UART_TX_PIN] == $past(uart_transmit))
      else $error("uart transmit not on its pin");

   cc_decode_a: assert property (@(posedge clk) disable iff (rst)
      xbar_en && cc_sel == 2'b10 |=> route.cc == 3'b011)
      else $error("capture compare decode wrong");

   pullup_ctl_a: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> pullup_en == ($past(pullup_off) ? '0 : $past(pin_digital)))
      else $error("pullup control wrong");

   cmp_gate_a: assert property (@(posedge clk) disable iff (rst)
      !(xbar_en && route_a[BIT_CMP]) |=> !fn_pin_out.cmp)
      else $error("comparator leaked to pin");

   nss_mode_a: assert property (@(posedge clk) disable iff (rst)
      xbar_en && route_a[BIT_SPI] |=> route.spi_core && route.spi_nss == $past(spi_four_wire))
      else $error("spi pin count wrong");

   sysclk_out_a: assert property (@(posedge clk) disable iff (rst)
      next_route.sysclk [*3] |-> sysclk_pin_out != $past(sysclk_pin_out))
      else $error("divided clock not toggling");

   mismatch_a: assert property (@(posedge clk) disable iff (rst)
      !$past(rst, 1) && !$past(rst, 2) && !$past(rst, 3) |->
      port_mismatch == |(($past(pin_in, 3) ^ $past({p1_match, p0_match}))
                         & $past({p1_mask, p0_mask})))
      else $error("mismatch disagrees with masked pins");

   wake_tie_a: assert property (@(posedge clk) disable iff (rst)
      mismatch_wake == port_mismatch && mismatch_irq_src == port_mismatch)
      else $error("wake or interrupt source differs");

   xbar_on_c: cover property (@(posedge clk) disable iff (rst)
      !xbar_en ##1 xbar_en ##2 pin_oe != '0);
   uart_on_c: cover property (@(posedge clk) disable iff (rst)
      route.uart && !pin_out[UART_TX_PIN]);
   mismatch_c: cover property (@(posedge clk) disable iff (rst)
      !port_mismatch ##1 port_mismatch);
endmodule // port_crossbar_and_match

// ### verilog/port_match_cmp.sv
// Pin synchroniser and masked match comparator for the port match event
`timescale 1ns/10ps
module port_match_cmp #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Raw pin levels and software compare setup
   input wire logic [W-1:0] pins,
   input wire logic [W-1:0] mask,
   input wire logic [W-1:0] match,
   // Registered compare result
   output logic mismatch
);
   logic [W-1:0] sync_a;
   logic [W-1:0] sync_b;
   logic [W-1:0] bit_diff;

   // Per pin: two-stage synchroniser, then masked inequality
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
         if (rst) begin
            sync_a[i] <= 1'b0;
            sync_b[i] <= 1'b0;
         end else begin
            sync_a[i] <= pins[i];
            sync_b[i] <= sync_a[i];
         end
      end
      // Mask low drops the pin; match gives the expected level
      assign bit_diff[i] = mask[i] & (sync_b[i] ^ match[i]);
   end

   // Level stays high while any included pin differs
   always_ff @(posedge clk) begin
      if (rst) begin
         mismatch <= 1'b0;
      end else begin
         mismatch <= |bit_diff;
      end
   end
endmodule // port_match_cmp
